/* File: core/clock_network_source_select_gate.sv */
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module clock_network_source_select_gate
  import clk_ctrl_pkg::*;
(
  // apb slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // device state
  input  wire logic                 user_mode,
  // clock sources, sampled levels
  input  wire logic [1:0]           ded_pin,
  input  wire logic [N_CNT-1:0]     pll_counter,
  input  wire logic [N_PLL-1:0]     pll_own_pin,
  input  wire logic [N_PLL-1:0]     center_pin,
  input  wire logic [N_FAB-1:0]     fabric_global,
  input  wire logic [N_FAB-1:0]     fabric_regional,
  input  wire logic [N_EXT-1:0]     ext_internal,
  // user logic
  input  wire logic [2*N_GLB-1:0]   run_time_source_select,
  input  wire logic [N_NET-1:0]     net_enable,
  // gated networks and pll references
  output logic      [N_GLB-1:0]     global_network,
  output logic      [N_RGN-1:0]     regional_network,
  output logic      [N_EXT-1:0]     external_pll_output_pin,
  output logic      [N_PLL-1:0]     pll_reference
);

  logic [CFG_W-1:0]  glb_cfg_q [N_GLB];
  logic [CFG_W-1:0]  rgn_cfg_q [N_RGN];
  logic [PCFG_W-1:0] pll_cfg_q [N_PLL];
  logic [N_EXT-1:0]  ext_cfg_q;
  logic [31:0]       prdata_q;
  logic [N_PLL-1:0]  pll_ref_q;

  logic [5:0]        word;
  logic              access;
  logic              mapped;
  logic              writable;
  logic              wr_ok;
  logic [31:0]       rd_mux;

  logic [1:0]        gsel     [N_GLB];
  logic [N_NET-1:0]  src;
  logic [N_NET-1:0]  pd;
  logic [N_NET-1:0]  mbyp;
  logic [N_NET-1:0]  rbyp;
  logic [N_NET-1:0]  use_alt;
  logic [N_NET-1:0]  alt;
  logic [N_NET-1:0]  en_sync;
  logic [N_NET-1:0]  eff;
  logic [N_NET-1:0]  falling;
  logic [N_NET-1:0]  prev_q;
  logic [N_NET-1:0]  meta_q;
  logic [N_NET-1:0]  ena_q;
  logic [N_NET-1:0]  out_q;
  logic [3:0]        pidx     [N_PLL];
  logic [N_PLL-1:0]  pll_d;

  // apb decode; zero wait states
  assign word     = paddr[7:2];
  assign access   = psel & penable;
  assign mapped   = (word <= WORD_STATUS) & (paddr[1:0] == 2'h0);
  assign writable = word < WORD_STATUS;
  // config is a loaded image: frozen while in user mode
  assign wr_ok    = access & pwrite & mapped & writable & ~user_mode;
  assign pready   = 1'b1;
  assign pslverr  = access & (~mapped | (pwrite & (~writable | user_mode)));
  assign prdata   = prdata_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (word < WORD_RGN0)
      rd_mux[CFG_W-1:0] = glb_cfg_q[word[1:0]];
    else if (word < WORD_PLL0)
      rd_mux[CFG_W-1:0] = rgn_cfg_q[word[1:0]];
    else if (word < WORD_EXT)
      rd_mux[PCFG_W-1:0] = pll_cfg_q[word[0]];
    else if (word == WORD_EXT)
      rd_mux[N_EXT-1:0] = ext_cfg_q;
    else if (word == WORD_STATUS)
    begin
      rd_mux[S_GLB +: N_GLB] = global_network;
      rd_mux[S_RGN +: N_RGN] = regional_network;
      rd_mux[S_EXT +: N_EXT] = external_pll_output_pin;
      rd_mux[S_PLL +: N_PLL] = pll_reference;
      rd_mux[S_USER]         = user_mode;
      rd_mux[S_ENA +: N_NET] = eff;
    end
    if (!mapped)
      rd_mux = 32'h0000_0000;
  end

  // read data captured in setup so it is a flop in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < N_GLB; i++)
        glb_cfg_q[i] <= NET_CFG_RST;
      for (int i = 0; i < N_RGN; i++)
        rgn_cfg_q[i] <= NET_CFG_RST;
      for (int i = 0; i < N_PLL; i++)
        pll_cfg_q[i] <= PLL_CFG_RST;
      ext_cfg_q <= EXT_CFG_RST;
    end
    else if (wr_ok)
    begin
      if (word < WORD_RGN0)
        glb_cfg_q[word[1:0]] <= pwdata[CFG_W-1:0];
      else if (word < WORD_PLL0)
        rgn_cfg_q[word[1:0]] <= pwdata[CFG_W-1:0];
      else if (word < WORD_EXT)
        pll_cfg_q[word[0]] <= pwdata[PCFG_W-1:0];
      else
        ext_cfg_q <= pwdata[N_EXT-1:0];
    end
  end

  // per-network source and gate settings
  always_comb
  begin
    for (int i = 0; i < N_GLB; i++)
    begin
      // run-time select ignored outside user mode
      gsel[i] = (user_mode && glb_cfg_q[i][F_DYN])
              ? run_time_source_select[2*i +: 2]
              : glb_cfg_q[i][F_SEL +: 2];
      unique case (gsel[i])
        2'h0: src[i] = ded_pin[0];
        2'h1: src[i] = ded_pin[1];
        // 2-bit counter fields cannot name counters above 3
        2'h2: src[i] = pll_counter[glb_cfg_q[i][F_CNT_A +: 2]];
        2'h3: src[i] = pll_counter[glb_cfg_q[i][F_CNT_B +: 2]];
      endcase
      pd[i]      = glb_cfg_q[i][F_PD];
      mbyp[i]    = glb_cfg_q[i][F_MBYP];
      rbyp[i]    = glb_cfg_q[i][F_RBYP];
      use_alt[i] = 1'b0;
      alt[i]     = 1'b0;
    end
    for (int i = 0; i < N_RGN; i++)
    begin
      // regional select comes from config only
      unique case (rgn_cfg_q[i][F_SEL +: 2])
        2'h0:    src[N_GLB+i] = ded_pin[0];
        2'h1:    src[N_GLB+i] = ded_pin[1];
        default: src[N_GLB+i] = pll_counter[rgn_cfg_q[i][F_RCNT +: 3]];
      endcase
      pd[N_GLB+i]      = rgn_cfg_q[i][F_PD];
      mbyp[N_GLB+i]    = rgn_cfg_q[i][F_MBYP];
      rbyp[N_GLB+i]    = rgn_cfg_q[i][F_RBYP];
      use_alt[N_GLB+i] = 1'b0;
      alt[N_GLB+i]     = 1'b0;
    end
    for (int j = 0; j < N_EXT; j++)
    begin
      src[N_GLB+N_RGN+j]     = pll_counter[j];
      pd[N_GLB+N_RGN+j]      = 1'b0;
      mbyp[N_GLB+N_RGN+j]    = 1'b0;
      rbyp[N_GLB+N_RGN+j]    = 1'b0;
      use_alt[N_GLB+N_RGN+j] = ~ext_cfg_q[j];
      alt[N_GLB+N_RGN+j]     = ext_internal[j];
    end
  end

  // one gate per network; pll counters are inputs only and never
  // reset or stalled here, so the loop keeps lock
  for (genvar k = 0; k < N_NET; k++)
  begin : g_net
    assign falling[k] = prev_q[k] & ~src[k];
    assign en_sync[k] = mbyp[k] ? net_enable[k] : meta_q[k];
    // register bypass trades clean edges for lower latency
    assign eff[k]     = rbyp[k] ? en_sync[k] : ena_q[k];

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        prev_q[k] <= 1'b0;
        meta_q[k] <= 1'b0;
        ena_q[k]  <= 1'b0;
        out_q[k]  <= 1'b0;
      end
      else
      begin
        prev_q[k] <= src[k];
        meta_q[k] <= net_enable[k];
        if (falling[k])
          ena_q[k] <= en_sync[k];
        if (use_alt[k])
          out_q[k] <= alt[k];
        else
          out_q[k] <= src[k] & eff[k] & ~pd[k];
      end
    end

    gate_low_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!eff[k] && !use_alt[k]) |=> !out_q[k])
      else $error("gated network high while disabled");

    pd_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pd[k] && $past(pd[k]) && !use_alt[k]) |-> !out_q[k])
      else $error("powered-down network toggled");

    fall_sample_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(ena_q[k]) |-> $past(prev_q[k]) && !$past(src[k]))
      else $error("enable changed off a falling edge");

    meta_stage_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (falling[k] && !mbyp[k] && $past(!mbyp[k]))
        |=> ena_q[k] == $past(net_enable[k], 2))
      else $error("metastability stage latency wrong");

    alt_pass_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      use_alt[k] |=> out_q[k] == $past(alt[k]))
      else $error("pin mux lost the internal signal");

    gate_pass_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!use_alt[k] && eff[k] && !pd[k]) |=> out_q[k] == $past(src[k]))
      else $error("enabled network did not follow its source");
  end

  assign global_network          = out_q[N_GLB-1:0];
  assign regional_network        = out_q[N_GLB +: N_RGN];
  assign external_pll_output_pin = out_q[N_GLB+N_RGN +: N_EXT];

  ext_no_bypass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    eff[N_NET-1:N_GLB+N_RGN] == ena_q[N_NET-1:N_GLB+N_RGN])
    else $error("external pin gate bypassed");

  // pll reference multiplexer, static config only
  always_comb
  begin
    for (int j = 0; j < N_PLL; j++)
    begin
      pidx[j] = SIDE_OFFSET[pll_cfg_q[j][F_PSIDE +: 2]]
              + {2'h0, pll_cfg_q[j][F_PSUB +: 2]};
      unique case (pll_cfg_q[j][F_PSRC +: 2])
        PSRC_PIN:    pll_d[j] = pll_own_pin[j];
        // fabric inputs assumed clean clocks from the far side
        PSRC_GLB:    pll_d[j] = fabric_global[pidx[j]];
        PSRC_RGN:    pll_d[j] = fabric_regional[pidx[j]];
        // direct path, not delay compensated
        PSRC_CENTER: pll_d[j] = center_pin[j];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pll_ref_q <= '0;
    else
      pll_ref_q <= pll_d;
  end

  assign pll_reference = pll_ref_q;

  pll_offset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pll_cfg_q[0][F_PSRC +: 2] == PSRC_GLB
      && pll_cfg_q[0][F_PSIDE +: 2] == 2'h3)
      |=> pll_reference[0]
          == $past(fabric_global[{2'h3, pll_cfg_q[0][F_PSUB +: 2]}]))
    else $error("pll fabric offset wrong for top side");

  cfg_frozen_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (user_mode && $past(user_mode))
      |-> $stable(pll_cfg_q[0]) && $stable(glb_cfg_q[0]))
    else $error("config changed in user mode");

  user_wr_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && user_mode) |-> pslverr && !wr_ok)
    else $error("user-mode config write not refused");

  static_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !user_mode |-> gsel[0] == glb_cfg_q[0][F_SEL +: 2])
    else $error("run-time select used outside user mode");

  rgn_static_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rgn_cfg_q[0][F_SEL +: 2] == 2'h0 |-> src[N_GLB] == ded_pin[0])
    else $error("regional source not from static config");

  dyn_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (user_mode && glb_cfg_q[0][F_DYN]
      && run_time_source_select[1:0] == 2'h1) |-> src[0] == ded_pin[1])
    else $error("run-time select did not pick pin input");

  ext_cfg_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ok && word == WORD_EXT) |=> ext_cfg_q == $past(pwdata[N_EXT-1:0]))
    else $error("external pin mux select not written");

  center_path_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pll_cfg_q[1][F_PSRC +: 2] == PSRC_CENTER
      |=> pll_reference[1] == $past(center_pin[1]))
    else $error("center pin path to pll input broken");

endmodule : clock_network_source_select_gate
`default_nettype wire

/* File: inc/clk_ctrl_pkg.sv */
package clk_ctrl_pkg;
  // network population
  localparam int N_GLB = 4;
  localparam int N_RGN = 4;
  localparam int N_EXT = 2;
  localparam int N_PLL = 2;
  localparam int N_NET = N_GLB + N_RGN + N_EXT;
  localparam int N_CNT = 8;
  localparam int N_FAB = 16;

  // register word indexes (byte address = 4 * index)
  localparam logic [5:0] WORD_GLB0   = 6'h00;
  localparam logic [5:0] WORD_RGN0   = 6'h04;
  localparam logic [5:0] WORD_PLL0   = 6'h08;
  localparam logic [5:0] WORD_EXT    = 6'h0A;
  localparam logic [5:0] WORD_STATUS = 6'h0B;

  // network config fields (global and regional words)
  localparam int F_SEL    = 0;
  localparam int F_DYN    = 2;
  localparam int F_PD     = 3;
  localparam int F_MBYP   = 4;
  localparam int F_RBYP   = 5;
  localparam int F_CNT_A  = 6;
  localparam int F_CNT_B  = 8;
  localparam int F_RCNT   = 6;
  localparam int CFG_W    = 10;

  // pll input config fields
  localparam int F_PSRC   = 0;
  localparam int F_PSIDE  = 2;
  localparam int F_PSUB   = 4;
  localparam int PCFG_W   = 6;

  // status word fields
  localparam int S_GLB    = 0;
  localparam int S_RGN    = 4;
  localparam int S_EXT    = 8;
  localparam int S_PLL    = 10;
  localparam int S_USER   = 12;
  localparam int S_ENA    = 16;

  // reset values: every global and regional network parked powered down
  localparam logic [CFG_W-1:0]  NET_CFG_RST = 10'h008;
  localparam logic [PCFG_W-1:0] PLL_CFG_RST = 6'h00;
  localparam logic [N_EXT-1:0]  EXT_CFG_RST = 2'h0;

  // pll input source codes
  localparam logic [1:0] PSRC_PIN    = 2'h0;
  localparam logic [1:0] PSRC_GLB    = 2'h1;
  localparam logic [1:0] PSRC_RGN    = 2'h2;
  localparam logic [1:0] PSRC_CENTER = 2'h3;

  // fabric index offset per pll side: left, bottom, right, top
  localparam logic [3:0] SIDE_OFFSET [4] = '{4'h0, 4'h4, 4'h8, 4'hC};
endpackage : clk_ctrl_pkg

/* File: sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import clk_ctrl_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, user_mode = 1'b0, tgl = 1'b0, err;
  logic [7:0]  paddr = 8'h00, req_sel = 8'h00, cnt_m = 8'h00;
  logic [7:0]  pll_counter = 8'h00, rtss;
  logic [9:0]  req_en = 10'h000, nen;
  logic [1:0]  ded_m = 2'h0, ext_m = 2'h0, c2, c3, xp, pr;
  logic [1:0]  ded_pin = 2'h0, ext_internal = 2'h0;
  logic [1:0]  ctr_pin = 2'h0;
  logic [15:0] fg_m = 16'h0000, fabric_global = 16'h0000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        pready, pslverr;
  logic [3:0]  gn, rn;
  wire  [11:0] outs = {pr, xp, rn, gn};
  int          miscompares = 0, tests_run = 0, cyc = 0, n;

  always #20 pclk = ~pclk;
  // oversampled clock levels; fabric inputs carry clocks only
  always @(posedge pclk)
  begin
    tgl <= ~tgl;
    ded_pin <= {2{tgl}} & ded_m;
    pll_counter <= {8{tgl}} & cnt_m;
    fabric_global <= {16{tgl}} & fg_m;
    ctr_pin <= {tgl, 1'b0};
    ext_internal <= {2{tgl}} & ext_m;
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      print_verdict;
    end
  end

  user_logic_model partner (.pclk(pclk), .presetn(presetn),
    .req_sel(req_sel), .req_en(req_en),
    .run_time_source_select(rtss), .net_enable(nen));

  clock_network_source_select_gate DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .user_mode(user_mode), .ded_pin(ded_pin), .pll_counter(pll_counter),
    .pll_own_pin(2'h0), .center_pin(ctr_pin), .fabric_global(fabric_global),
    .fabric_regional(16'h0000), .ext_internal(ext_internal),
    .run_time_source_select(rtss), .net_enable(nen),
    .global_network(gn), .regional_network(rn),
    .external_pll_output_pin(xp), .pll_reference(pr));

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // activity of one output over 16 cycles, after the enable path settles
  task act(input int b, input logic exp);
    int k;
    n = 0;
    repeat (8) @(posedge pclk);
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (outs[b] === 1'b1) n++;
    end
    chk({32'h0, n > 0}, {32'h0, exp});
  endtask : act

  function automatic logic [31:0] gcfg(logic [1:0] sel, logic dyn,
                                       logic [1:0] a, logic [1:0] b);
    return {22'h0, b, a, 3'h0, dyn, sel};
  endfunction : gcfg

  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    n = $urandom(32'h57D6);
    c2 = 2'($urandom);
    c3 = 2'($urandom);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk({err, rd}, {1'b0, 22'h0, NET_CFG_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd}, {1'b0, 22'h0, NET_CFG_RST});
    apb(1'b0, 8'h30, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    // parked networks stay dark even with enable and a live source
    req_en <= 10'h3FF;
    ded_m <= 2'h3;
    act(0, 1'b0);
    apb(1'b1, 8'h00, gcfg(2'h0, 1'b1, c2, c3));
    apb(1'b1, 8'h04, gcfg(2'h1, 1'b0, 2'h0, 2'h0));
    // regional 0 runs with both enable registers bypassed
    apb(1'b1, 8'h10, 32'h30);
    // pll 0 from the top side, sub index 3; pll 1 from its center pin
    apb(1'b1, 8'h20, 32'h3D);
    apb(1'b1, 8'h24, 32'h3);
    apb(1'b1, 8'h28, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk({err, rd}, {1'b0, gcfg(2'h0, 1'b1, c2, c3)});
    user_mode <= 1'b1;
    apb(1'b1, 8'h04, 32'h8);
    chk({32'h0, err}, 33'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk({err, rd}, {1'b0, gcfg(2'h1, 1'b0, 2'h0, 2'h0)});
    for (int s = 0; s < 4; s++)
    begin
      req_sel <= {6'($urandom), 2'(s)};
      ded_m <= (s < 2) ? 2'(1 << s) : 2'h0;
      cnt_m <= (s == 2) ? 8'(1 << c2) : (s == 3) ? 8'(1 << c3) : 8'h0;
      act(0, 1'b1);
      act(1, s == 1);
      act(4, s == 0);
    end
    req_en <= 10'h3FE;
    ded_m <= 2'h1;
    act(0, 1'b0);
    act(4, 1'b1);
    fg_m <= 16'h8000;
    act(10, 1'b1);
    fg_m <= 16'h0800;
    act(10, 1'b0);
    act(11, 1'b1);
    ext_m <= 2'h1;
    act(8, 1'b1);
    cnt_m <= 8'h02;
    req_en <= 10'h1FF;
    act(9, 1'b0);
    req_en <= 10'h3FF;
    act(9, 1'b1);
    req_en <= 10'h3EF;
    act(4, 1'b0);
    print_verdict;
  end
endmodule : tb
`default_nettype wire

/* File: sim/user_logic_model.sv */
`timescale 1ns/100ps
`default_nettype none
module user_logic_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench commands
  input  wire logic [7:0] req_sel,
  input  wire logic [9:0] req_en,
  // to the block
  output logic      [7:0] run_time_source_select,
  output logic      [9:0] net_enable
);
  // fabric flops: change just after a rising edge, never mid-cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      run_time_source_select <= 8'h00;
      net_enable             <= 10'h000;
    end
    else
    begin
      run_time_source_select <= req_sel;
      net_enable             <= req_en;
    end
endmodule : user_logic_model
`default_nettype wire
